// ==== verification/cfg_memory_model.sv ====
// ****************************************
// Configuration memory model
// ****************************************
module cfg_memory_model (
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic slow_i,
    input wire logic late_i,
    input wire logic [6:0] skip_i,
    input wire logic [6:0][15:0] words_i,
    output logic word_valid_o,
    output logic [7:0] word_addr_o,
    output logic [15:0] word_data_o,
    output logic load_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Last entry is an address the loader must ignore
    localparam logic [6:0][7:0] ADDRS = {8'h4c, 8'h53, 8'h52, 8'h51, 8'h50, 8'h4a, 8'h40};

    // Released lines flip so stale data never looks valid
    task automatic idle();
        word_valid_o = 1'b0;
        word_addr_o = ~word_addr_o;
        word_data_o = ~word_data_o;
    endtask : idle

    task automatic beat(input logic [7:0] a, input logic [15:0] d);
        word_valid_o = 1'b1;
        word_addr_o = a;
        word_data_o = d;
        @(negedge clk_i);
        if (slow_i) begin
            idle();
            repeat (3) @(negedge clk_i);
        end
    endtask : beat

    initial begin
        word_valid_o = 1'b0;
        word_addr_o = '0;
        word_data_o = '0;
        load_done_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (start_i) begin
                @(negedge clk_i);
                for (int i = 0; i < 7; i++) begin
                    if (!skip_i[i]) begin
                        beat(ADDRS[i], words_i[i]);
                    end
                end
                idle();
                load_done_o = 1'b1;
                @(negedge clk_i);
                load_done_o = 1'b0;
                // Late word must be ignored
                if (late_i) begin
                    beat(8'h4a, ~words_i[1]);
                    idle();
                end
            end
        end
    end
endmodule : cfg_memory_model

// ==== verification/loader_monitor.sv ====
// ****************************************
// Loader checker
// ****************************************
module loader_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic word_valid_i,
    input wire logic [loader_pkg::ADDR_W-1:0] word_addr_i,
    input wire logic [loader_pkg::WORD_W-1:0] word_data_i,
    input wire logic load_done_i,
    input wire loader_pkg::tuning_fields_type port0_tuning_o,
    input wire loader_pkg::tuning_fields_type port5_tuning_o,
    input wire loader_pkg::pm_fields_type port0_pm_o,
    input wire loader_pkg::pm_fields_type port1_pm_o,
    input wire logic cfg_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic taken_reg;
    logic [15:0] w_reg [0:7];
    logic [2:0] idx;
    loader_pkg::tuning_fields_type exp_p0, exp_p5;
    loader_pkg::pm_fields_type exp_pm0, exp_pm1;

    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    always_comb begin
        case (word_addr_i)
            8'h40: idx = 3'h0;
            8'h4a: idx = 3'h1;
            8'h50: idx = 3'h2;
            8'h51: idx = 3'h3;
            8'h52: idx = 3'h4;
            8'h53: idx = 3'h5;
            default: idx = 3'h7;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            taken_reg <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                w_reg[i] <= '0;
            end
        end else begin
            taken_reg <= taken_reg | load_done_i;
            if (word_valid_i && !taken_reg) begin
                w_reg[idx] <= word_data_i;
            end
        end
    end

    // Port 0 has no de-emphasis source
    assign exp_p0 = {w_reg[0][4:0], w_reg[0][11:5], 1'b0, w_reg[0][13], w_reg[0][15:14]};
    assign exp_p5 = {w_reg[1][4:0], w_reg[1][11:5], w_reg[1][12], w_reg[1][13], w_reg[1][15:14]};
    assign exp_pm0 = {w_reg[2][0], w_reg[2][3:1], w_reg[2][4], w_reg[2][5], w_reg[2][7:6],
        w_reg[3][15:8]};
    assign exp_pm1 = {w_reg[4][0], w_reg[4][3:1], w_reg[4][4], w_reg[4][5], w_reg[4][7:6],
        w_reg[5][15:8]};

    reset_defaults_a: assert property (
        $fell(rst_i) |-> !cfg_ready_o && port0_tuning_o == '0 && port5_tuning_o == '0
            && port0_pm_o == '0 && port1_pm_o == '0)
        else $error("outputs not at defaults after reset");
    ready_timing_a: assert property (
        load_done_i && !taken_reg |-> !cfg_ready_o [*8] ##1 cfg_ready_o)
        else $error("ready not seen eight cycles after load done");
    ready_hold_a: assert property (cfg_ready_o |=> cfg_ready_o)
        else $error("ready dropped");
    fields_frozen_a: assert property (
        cfg_ready_o |=> $stable(port0_tuning_o) && $stable(port5_tuning_o)
            && $stable(port0_pm_o) && $stable(port1_pm_o))
        else $error("field changed after ready");
    slot_order_a: assert property (
        load_done_i && !taken_reg |-> ##3 port0_tuning_o == exp_p0 && port5_tuning_o == '0
            ##1 port5_tuning_o == exp_p5
            ##1 port0_pm_o[15:8] == exp_pm0[15:8] && port1_pm_o == '0
            ##2 port1_pm_o[15:8] == exp_pm1[15:8])
        else $error("slot update order wrong");
    port5_tuning_a: assert property (
        cfg_ready_o |-> port5_tuning_o == exp_p5)
        else $error("port 5 tuning wrong");
    port0_tuning_a: assert property (cfg_ready_o |-> port0_tuning_o == exp_p0)
        else $error("port 0 tuning wrong");
    port0_power_a: assert property (
        cfg_ready_o |-> port0_pm_o == exp_pm0)
        else $error("port 0 power fields wrong");
    port1_power_a: assert property (cfg_ready_o |-> port1_pm_o == exp_pm1)
        else $error("port 1 power fields wrong");
endmodule : loader_monitor

bind config_word_loader loader_monitor loader_monitor_inst (
    .clk_i(clk_i), .rst_i(rst_i), .word_valid_i(word_valid_i), .word_addr_i(word_addr_i),
    .word_data_i(word_data_i), .load_done_i(load_done_i), .port0_tuning_o(port0_tuning_o),
    .port5_tuning_o(port5_tuning_o), .port0_pm_o(port0_pm_o), .port1_pm_o(port1_pm_o),
    .cfg_ready_o(cfg_ready_o)
);

// ==== verification/tb.sv ====
// ****************************************
// Loader bench
// ****************************************
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic start = 1'b0;
    logic slow = 1'b0;
    logic late = 1'b0;
    logic [6:0] skip = '0;
    logic [6:0][15:0] words = '0;
    logic valid;
    logic [7:0] addr;
    logic [15:0] data;
    logic done;
    logic ready;
    loader_pkg::tuning_fields_type p0_tune, p5_tune;
    loader_pkg::pm_fields_type p0_pm, p1_pm;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    int e [0:6];

    always #5 clk_i = ~clk_i;

    cfg_memory_model cfg_memory_model_inst (
        .clk_i(clk_i), .start_i(start), .slow_i(slow), .late_i(late), .skip_i(skip),
        .words_i(words), .word_valid_o(valid), .word_addr_o(addr), .word_data_o(data),
        .load_done_o(done)
    );
    config_word_loader config_word_loader_inst (
        .clk_i(clk_i), .rst_i(rst_i), .word_valid_i(valid), .word_addr_i(addr),
        .word_data_i(data), .load_done_i(done), .port0_tuning_o(p0_tune),
        .port5_tuning_o(p5_tune), .port0_pm_o(p0_pm), .port1_pm_o(p1_pm), .cfg_ready_o(ready)
    );

    function automatic int tune(input int w, input int de);
        return ((w & 31) << 11) | (((w >> 5) & 127) << 4) | (de * ((w >> 12) & 1) << 3)
            | (((w >> 13) & 1) << 2) | ((w >> 14) & 3);
    endfunction : tune

    function automatic int power(input int w, input int d);
        return ((w & 1) << 15) | (((w >> 1) & 7) << 12) | (((w >> 4) & 1) << 11)
            | (((w >> 5) & 1) << 10) | (((w >> 6) & 3) << 8) | ((d >> 8) & 255);
    endfunction : power

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    // Whole run needs well under this
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            report_and_stop();
        end
    end

    initial begin
        void'($urandom(5420));
        for (int r = 0; r < 6; r++) begin
            rst_i = 1'b1;
            repeat (5) @(negedge clk_i);
            rst_i = 1'b0;
            @(negedge clk_i);
            check("idle_ready", 16'(ready), 16'h0);
            check("idle_port1_pm", p1_pm, 16'h0);
            for (int i = 0; i < 7; i++) begin
                words[i] = 16'($urandom);
            end
            // Later runs drop words to see defaults survive
            skip = (r > 1) ? 7'($urandom) : 7'h00;
            slow = r[0];
            late = r[1];
            start = 1'b1;
            @(negedge clk_i);
            start = 1'b0;
            for (int n = 0; n < 100 && ready !== 1'b1; n++) begin
                @(negedge clk_i);
            end
            repeat (4) @(negedge clk_i);
            for (int i = 0; i < 7; i++) begin
                e[i] = skip[i] ? 0 : int'(words[i]);
            end
            check("ready", 16'(ready), 16'h1);
            check("port5_tuning", p5_tune, 16'(tune(e[1], 1)));
            check("port0_tuning", p0_tune, 16'(tune(e[0], 0)));
            check("port0_pm", p0_pm, 16'(power(e[2], e[3])));
            check("port1_pm", p1_pm, 16'(power(e[4], e[5])));
        end
        report_and_stop();
    end
endmodule : tb

// ==== verilog/config_word_loader.sv ====
// What this block does
// - Word 4Ah bits 4:0 go to port 5 offset 7Ch bits 12:8.
// - Word 4Ah bits 11:5 go to port 5 offset 90h bits 6:0.
// - Word 4Ah bit 12 goes to port 5 de-emphasis, offset F0h bit 6.
// - Word 4Ah bit 13 goes to port 5 compliance-to-detect, 78h bit 11.
// - Word 4Ah bits 15:14 go to port 5 data change count select.
// - Word 50h bit 0 goes to port 0 no-soft-reset, 44h bit 3.
// - Word 50h bits 3:1 go to port 0 aux current, 40h bits 24:22.
// - Power word bit 4 sets read-only D1 support, 40h bit 25.
// - Power word bit 5 sets read-only D2 support, 40h bit 26.
// - Power word bits 7:6 set PME support bits 29:28.
// - Word 51h bits 15:8 give port 0 read-only power data.
// - Word 52h loads port 1 power fields with the same layout.
// - Word 53h bits 15:8 give port 1 read-only power data.
// - Word 40h loads port 0 tuning fields with the same layout, except bit 12, which is ignored (no de-emphasis).
package loader_pkg;

    // ****************************************
    // Word addresses and store slots
    // ****************************************
    localparam int WORD_W = 16;
    localparam int ADDR_W = 8;
    localparam int SLOT_W = 3;
    localparam int NUM_SLOTS = 6;
    localparam logic [ADDR_W-1:0] ADDR_P0_TUNE = 8'h40;
    localparam logic [ADDR_W-1:0] ADDR_P5_TUNE = 8'h4a;
    localparam logic [ADDR_W-1:0] ADDR_P0_PM = 8'h50;
    localparam logic [ADDR_W-1:0] ADDR_P0_PMDATA = 8'h51;
    localparam logic [ADDR_W-1:0] ADDR_P1_PM = 8'h52;
    localparam logic [ADDR_W-1:0] ADDR_P1_PMDATA = 8'h53;
    localparam logic [SLOT_W-1:0] SLOT_P0_TUNE = 3'h0;
    localparam logic [SLOT_W-1:0] SLOT_P5_TUNE = 3'h1;
    localparam logic [SLOT_W-1:0] SLOT_P0_PM = 3'h2;
    localparam logic [SLOT_W-1:0] SLOT_P0_PMDATA = 3'h3;
    localparam logic [SLOT_W-1:0] SLOT_P1_PM = 3'h4;
    localparam logic [SLOT_W-1:0] SLOT_P1_PMDATA = 3'h5;
    localparam logic [SLOT_W-1:0] SLOT_LAST = 3'h5;

    // ****************************************
    // Source bit positions in a word
    // ****************************************
    localparam int TUNE_PHY2_LSB = 0;
    localparam int TUNE_PHY3_LSB = 5;
    localparam int TUNE_DEEMPH_BIT = 12;
    localparam int TUNE_COMPL_BIT = 13;
    localparam int TUNE_DCHG_LSB = 14;
    localparam int PM_NSR_BIT = 0;
    localparam int PM_AUX_LSB = 1;
    localparam int PM_D1_BIT = 4;
    localparam int PM_D2_BIT = 5;
    localparam int PM_PME_LSB = 6;
    localparam int PM_DATA_LSB = 8;

    // ****************************************
    // Field carriers
    // ****************************************
    // 7Ch[12:8], 90h[6:0], F0h[6], 78h[11], 8Ch[9:8]
    typedef struct packed {
        logic [4:0] phy_param2;
        logic [6:0] phy_param3;
        logic deemphasis_select;
        logic compliance_to_detect;
        logic [1:0] data_change_count_select;
    } tuning_fields_type;

    // 44h[3], 40h[24:22], 40h[25], 40h[26], 40h[29:28], 44h[31:24]
    typedef struct packed {
        logic no_soft_reset;
        logic [2:0] aux_current;
        logic d1_support;
        logic d2_support;
        logic [1:0] pme_support;
        logic [7:0] pm_data;
    } pm_fields_type;

    localparam tuning_fields_type TUNING_RESET = '0;
    localparam pm_fields_type PM_RESET = '0;

    typedef enum {
        ST_CAPTURE,
        ST_APPLY,
        ST_READY
    } load_state_type;

    function automatic logic [SLOT_W-1:0] slot_of(input logic [ADDR_W-1:0] addr);
        logic [SLOT_W-1:0] s;
        s = SLOT_P0_TUNE;
        case (addr)
            ADDR_P0_TUNE: s = SLOT_P0_TUNE;
            ADDR_P5_TUNE: s = SLOT_P5_TUNE;
            ADDR_P0_PM: s = SLOT_P0_PM;
            ADDR_P0_PMDATA: s = SLOT_P0_PMDATA;
            ADDR_P1_PM: s = SLOT_P1_PM;
            ADDR_P1_PMDATA: s = SLOT_P1_PMDATA;
            default: s = SLOT_P0_TUNE;
        endcase
        return s;
    endfunction : slot_of

    function automatic logic is_known(input logic [ADDR_W-1:0] addr);
        return (addr == ADDR_P0_TUNE) || (addr == ADDR_P5_TUNE) ||
               (addr == ADDR_P0_PM) || (addr == ADDR_P0_PMDATA) ||
               (addr == ADDR_P1_PM) || (addr == ADDR_P1_PMDATA);
    endfunction : is_known

    // Tuning layout; port 0 has no de-emphasis entry so it keeps the old value
    function automatic tuning_fields_type tune_from_word(
        input logic [WORD_W-1:0] w,
        input logic with_deemph,
        input tuning_fields_type old
    );
        tuning_fields_type t;
        t = old;
        t.phy_param2 = w[TUNE_PHY2_LSB +: 5];
        t.phy_param3 = w[TUNE_PHY3_LSB +: 7];
        if (with_deemph) begin
            t.deemphasis_select = w[TUNE_DEEMPH_BIT];
        end
        t.compliance_to_detect = w[TUNE_COMPL_BIT];
        t.data_change_count_select = w[TUNE_DCHG_LSB +: 2];
        return t;
    endfunction : tune_from_word

    // Capability half of a power word; data byte comes from its own word
    function automatic pm_fields_type pm_from_word(
        input logic [WORD_W-1:0] w,
        input pm_fields_type old
    );
        pm_fields_type p;
        p = old;
        p.no_soft_reset = w[PM_NSR_BIT];
        p.aux_current = w[PM_AUX_LSB +: 3];
        p.d1_support = w[PM_D1_BIT];
        p.d2_support = w[PM_D2_BIT];
        p.pme_support = w[PM_PME_LSB +: 2];
        return p;
    endfunction : pm_from_word

    function automatic pm_fields_type pm_data_from_word(
        input logic [WORD_W-1:0] w,
        input pm_fields_type old
    );
        pm_fields_type p;
        p = old;
        p.pm_data = w[PM_DATA_LSB +: 8];
        return p;
    endfunction : pm_data_from_word

endpackage : loader_pkg

// ****************************************
// Configuration word loader
// ****************************************
module config_word_loader (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic word_valid_i,
    input wire logic [loader_pkg::ADDR_W-1:0] word_addr_i,
    input wire logic [loader_pkg::WORD_W-1:0] word_data_i,
    input wire logic load_done_i,
    output loader_pkg::tuning_fields_type port0_tuning_o,
    output loader_pkg::tuning_fields_type port5_tuning_o,
    output loader_pkg::pm_fields_type port0_pm_o,
    output loader_pkg::pm_fields_type port1_pm_o,
    output logic cfg_ready_o
);

    loader_pkg::load_state_type state_reg;
    loader_pkg::load_state_type state_next;
    logic [loader_pkg::NUM_SLOTS-1:0] loaded_reg;
    logic [loader_pkg::SLOT_W-1:0] issue_idx_reg;
    logic issue_active_reg;
    logic [loader_pkg::SLOT_W-1:0] apply_slot_reg;
    logic apply_valid_reg;
    logic [loader_pkg::WORD_W-1:0] rd_data;
    logic capture_hit;
    logic [loader_pkg::SLOT_W-1:0] capture_slot;
    logic apply_last;

    // ****************************************
    // Word capture
    // ****************************************
    // words outside the known set are ignored
    assign capture_hit = (state_reg == loader_pkg::ST_CAPTURE) && word_valid_i &&
                         loader_pkg::is_known(word_addr_i);
    assign capture_slot = loader_pkg::slot_of(word_addr_i);

    word_store #(
        .WIDTH(loader_pkg::WORD_W),
        .DEPTH(loader_pkg::NUM_SLOTS),
        .AW(loader_pkg::SLOT_W)
    ) store_inst (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_en_i(capture_hit),
        .wr_addr_i(capture_slot),
        .wr_data_i(word_data_i),
        .rd_addr_i(issue_idx_reg),
        .rd_data_o(rd_data)
    );

    // only slots really loaded overwrite defaults
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            loaded_reg <= '0;
        end else if (capture_hit) begin
            loaded_reg[capture_slot] <= 1'b1;
        end
    end

    // ****************************************
    // Sequencing
    // ****************************************
    assign apply_last = apply_valid_reg && (apply_slot_reg == loader_pkg::SLOT_LAST);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            loader_pkg::ST_CAPTURE: begin
                if (load_done_i) begin
                    state_next = loader_pkg::ST_APPLY;
                end
            end
            loader_pkg::ST_APPLY: begin
                if (apply_last) begin
                    state_next = loader_pkg::ST_READY;
                end
            end
            loader_pkg::ST_READY: begin
                state_next = loader_pkg::ST_READY;
            end
            default: begin
                state_next = loader_pkg::ST_CAPTURE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= loader_pkg::ST_CAPTURE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Read address walks the slots once; data lands one cycle later
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            issue_idx_reg <= '0;
            issue_active_reg <= 1'b0;
        end else if (state_reg == loader_pkg::ST_CAPTURE && load_done_i) begin
            issue_idx_reg <= '0;
            issue_active_reg <= 1'b1;
        end else if (issue_active_reg) begin
            if (issue_idx_reg == loader_pkg::SLOT_LAST) begin
                issue_active_reg <= 1'b0;
            end else begin
                issue_idx_reg <= issue_idx_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            apply_slot_reg <= '0;
            apply_valid_reg <= 1'b0;
        end else begin
            apply_slot_reg <= issue_idx_reg;
            apply_valid_reg <= issue_active_reg;
        end
    end

    // ****************************************
    // Field update
    // ****************************************
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            port0_tuning_o <= loader_pkg::TUNING_RESET;
            port5_tuning_o <= loader_pkg::TUNING_RESET;
        end else if (apply_valid_reg && loaded_reg[apply_slot_reg]) begin
            if (apply_slot_reg == loader_pkg::SLOT_P0_TUNE) begin
                port0_tuning_o <= loader_pkg::tune_from_word(rd_data, 1'b0, port0_tuning_o);
            end
            if (apply_slot_reg == loader_pkg::SLOT_P5_TUNE) begin
                port5_tuning_o <= loader_pkg::tune_from_word(rd_data, 1'b1, port5_tuning_o);
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            port0_pm_o <= loader_pkg::PM_RESET;
            port1_pm_o <= loader_pkg::PM_RESET;
        end else if (apply_valid_reg && loaded_reg[apply_slot_reg]) begin
            case (apply_slot_reg)
                loader_pkg::SLOT_P0_PM: begin
                    port0_pm_o <= loader_pkg::pm_from_word(rd_data, port0_pm_o);
                end
                loader_pkg::SLOT_P0_PMDATA: begin
                    port0_pm_o <= loader_pkg::pm_data_from_word(rd_data, port0_pm_o);
                end
                loader_pkg::SLOT_P1_PM: begin
                    port1_pm_o <= loader_pkg::pm_from_word(rd_data, port1_pm_o);
                end
                loader_pkg::SLOT_P1_PMDATA: begin
                    port1_pm_o <= loader_pkg::pm_data_from_word(rd_data, port1_pm_o);
                end
                default: begin
                    port0_pm_o <= port0_pm_o;
                end
            endcase
        end
    end

    // ports answer only after last field
    assign cfg_ready_o = (state_reg == loader_pkg::ST_READY);

endmodule : config_word_loader

// ==== verilog/word_store.sv ====
// ****************************************
// Small word store, registered read data
// ****************************************
module word_store #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 6,
    parameter int AW = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [WIDTH-1:0] rd_data_o
);

    logic [WIDTH-1:0] mem [DEPTH];

    // No reset on the array; a slot's data is only used once written
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= mem[rd_addr_i];
        end
    end

endmodule : word_store
